// ===== fpi_defs.vh
`ifndef FPI_DEFS_VH
`define FPI_DEFS_VH

// ----------------------------------------------------------------
// master-to-device block layout
// ----------------------------------------------------------------
`define FPI_OB_BYTES     16
`define FPI_OB_CMD       4'h0
`define FPI_OB_CNT       4'h1
`define FPI_OB_ADR_HI    4'h2
`define FPI_OB_ADR_LO    4'h3
`define FPI_OB_WDAT      4'h4
`define FPI_WR_REGS      8'h06

// ----------------------------------------------------------------
// device-to-master base block layout
// ----------------------------------------------------------------
`define FPI_IB_BYTES     8'h20
`define FPI_IB_ERR_HI    5'h00
`define FPI_IB_ERR_LO    5'h01
`define FPI_IB_STAT_HI   5'h02
`define FPI_IB_STAT_LO   5'h03
`define FPI_IB_ACK       5'h04
`define FPI_IB_CERR      5'h05
`define FPI_IB_WIN_HI    5'h06
`define FPI_IB_WIN_LO    5'h07
`define FPI_RD_REGS      12

// ----------------------------------------------------------------
// configurable data blocks
// ----------------------------------------------------------------
`define FPI_BLK_MAX      4'hC
`define FPI_BLK_FIRST    4'h2
`define FPI_TYPE_W       5
`define FPI_TYPE_UNUSED  5'h00
`define FPI_FB_W         4

// ----------------------------------------------------------------
// command codes and answers
// ----------------------------------------------------------------
`define FPI_CMD_NONE     8'h00
`define FPI_CMD_WIN      8'hFA
`define FPI_CMD_WRITE    8'hFB
`define FPI_CMD_CLRPR    8'hFC
`define FPI_ACK_FAIL     8'hF0
`define FPI_ERR_COUNT    8'h01
`define FPI_ERR_NONE     8'h00

// ----------------------------------------------------------------
// status word and reset values
// ----------------------------------------------------------------
`define FPI_STAT_PRST    0
`define FPI_PRST_RST     1'b1
`define FPI_WIN_RST      16'h0000

`endif

// ===== fpi_blk_fmt.v
`timescale 1ns/1ps
`include "fpi_defs.vh"

module fpi_blk_fmt (
  input  wire        fmt_int_in,
  input  wire [3:0]  off_in,
  input  wire [31:0] err_in,
  input  wire [31:0] stat_in,
  input  wire [31:0] a_in,
  input  wire [15:0] adec_in,
  input  wire [31:0] b_in,
  input  wire [15:0] bdec_in,
  output wire [7:0]  byte_out
);

  // ----------------------------------------------------------------
  // packing of the sixteen block bytes, msb first
  // ----------------------------------------------------------------
  wire [127:0] flt_img;   // error, status, value a, value b
  wire [127:0] int_img;   // short error/status, int and decimal parts
  wire [127:0] img;       // chosen format
  wire [6:0]   bit_sel;   // low bit of selected byte

  // float: four 32-bit fields at +0, +4, +8, +12
  assign flt_img = {err_in, stat_in, a_in, b_in};
  // integer: 2+2+4+2+4+2 bytes
  assign int_img = {err_in[15:0], stat_in[15:0], a_in, adec_in, b_in, bdec_in};
  assign img     = fmt_int_in ? int_img : flt_img;
  // byte 0 is the top byte of the image
  assign bit_sel  = {~off_in, 3'b000};
  assign byte_out = img[bit_sel +: 8];

endmodule

// ===== fpi_process_image.v
`timescale 1ns/1ps
`include "fpi_defs.vh"
// How it works
// - sixteen-byte command block always mapped
// - cmd, count, start msb-first, six write words
// - 0 idle, FA moves window, FB writes
// - FC clears program-reset status bit
// - only a changed command byte executes
// - start address selects first target register
// - thirty-two-byte base block always leads image
// - error, status, ack, error, window, twelve reads
// - error word zero when nothing is wrong
// - ack echoes code, or F0 on failure
// - error byte holds reason, zero on success
// - window start shown in bytes six-seven
// - twelve read registers refreshed continuously
// - blocks at 32 plus 16 per block
// - each block carries one selected content type
// - float block: error, status, sum, difference
// - integer block: short fields, int plus decimal
// - function-block index per block from configuration
// - every register is a sixteen-bit word
// - unused blocks read as zero
// - active block count zero to twelve

module fpi_process_image (
  input  wire        CLK_SYS_IN,
  input  wire        RST_N_IN,
  input  wire        CE_IN,
  input  wire        OIMG_WR_IN,
  input  wire [3:0]  OIMG_ADDR_IN,
  input  wire [7:0]  OIMG_DATA_IN,
  input  wire [7:0]  IIMG_ADDR_IN,
  output reg  [7:0]  IIMG_DATA_OUT,
  input  wire [15:0] INST_ERR_IN,
  input  wire [15:0] INST_STAT_IN,
  input  wire        PRG_RST_SET_IN,
  input  wire [3:0]  NBLK_IN,
  input  wire [59:0] BLK_TYPE_IN,
  input  wire [11:0] BLK_FMT_IN,
  input  wire [47:0] BLK_FB_IN,
  output reg  [4:0]  VAL_TYPE_OUT,
  output reg  [3:0]  VAL_FB_OUT,
  input  wire [31:0] VAL_ERR_IN,
  input  wire [31:0] VAL_STAT_IN,
  input  wire [31:0] VAL_A_IN,
  input  wire [15:0] VAL_ADEC_IN,
  input  wire [31:0] VAL_B_IN,
  input  wire [15:0] VAL_BDEC_IN,
  output reg  [15:0] REG_RADDR_OUT,
  input  wire [15:0] REG_RDATA_IN,
  output reg         REG_WR_OUT,
  output reg  [15:0] REG_WADDR_OUT,
  output reg  [15:0] REG_WDATA_OUT,
  input  wire [7:0]  REG_WERR_IN,
  output reg         CMD_STB_OUT,
  output reg  [7:0]  CMD_CODE_OUT,
  input  wire        CMD_DONE_IN,
  input  wire [7:0]  CMD_ERR_IN,
  output wire        BUSY_OUT
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;   // waiting for a changed command
  localparam [1:0] ST_WR   = 2'd1;   // issue one register write
  localparam [1:0] ST_WCHK = 2'd2;   // judge the write just issued
  localparam [1:0] ST_EXT  = 2'd3;   // other command, wait for done

  wire [127:0] ob_flat;              // master-to-device bytes
  wire [191:0] rd_flat;              // twelve read-window words
  wire [4:0]   cfg_type [0:11];      // per-block content type
  wire [3:0]   cfg_fb   [0:11];      // per-block function block
  wire [7:0]   cmd_byte;             // live command byte
  wire [7:0]   cnt_byte;             // live register count
  wire [15:0]  start_w;              // live start address
  wire [3:0]   wbyte;                // msb byte of current write word
  wire [3:0]   nblk_eff;             // block count clamped to twelve
  wire [3:0]   blk_in;               // block number of requested byte
  wire         blk_used;             // requested byte is in an active block
  wire [3:0]   ridx_nx;              // next scan index
  wire [3:0]   rsel;                 // read word for a base-block byte
  wire [15:0]  rword;                // selected read word
  wire [7:0]   fmt_byte;             // formatted data-block byte
  wire [15:0]  stat_word;            // status with program-reset bit

  reg  [1:0]   state_q;              // command sequencer state
  reg  [7:0]   prev_q;               // last command byte seen
  reg  [7:0]   code_q;               // command being executed
  reg  [7:0]   ack_q;                // command acknowledge byte
  reg  [7:0]   cerr_q;               // command error byte
  reg  [15:0]  win_q;                // read window start
  reg  [7:0]   cnt_q;                // latched write count
  reg  [15:0]  start_q;              // latched write start
  reg  [2:0]   idx_q;                // write word index
  reg          prst_q;               // program-reset indication
  reg  [3:0]   scan_q;               // read scan index
  reg  [3:0]   ridx_q;               // index of word now on the read port
  reg  [7:0]   a_q;                  // image address, stage one
  reg          fmt_q;                // integer format, stage one

  // ----------------------------------------------------------------
  // per-entry storage and configuration unpacking
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_ob
      localparam [3:0] IDX = g;
      reg [7:0] b_q;
      // master writes one byte of the fixed block
      always @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
          b_q <= 8'h00;
        end else if (CE_IN && OIMG_WR_IN && OIMG_ADDR_IN == IDX) begin
          b_q <= OIMG_DATA_IN;
        end
      end
      assign ob_flat[g*8 +: 8] = b_q;
    end
    for (g = 0; g < 12; g = g + 1) begin : g_rd
      localparam [3:0] IDX = g;
      reg [15:0] w_q;
      // capture the word answered for this window slot
      always @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
          w_q <= 16'h0000;
        end else if (CE_IN && ridx_q == IDX) begin
          w_q <= REG_RDATA_IN;
        end
      end
      assign rd_flat[g*16 +: 16] = w_q;
      assign cfg_type[g] = BLK_TYPE_IN[g*5 +: 5];
      assign cfg_fb[g]   = BLK_FB_IN[g*4 +: 4];
    end
  endgenerate

  // ----------------------------------------------------------------
  // field extraction from the master block
  // ----------------------------------------------------------------
  assign cmd_byte = ob_flat[8*`FPI_OB_CMD +: 8];
  assign cnt_byte = ob_flat[8*`FPI_OB_CNT +: 8];
  // start address is msb first
  assign start_w  = {ob_flat[8*`FPI_OB_ADR_HI +: 8], ob_flat[8*`FPI_OB_ADR_LO +: 8]};
  // word i sits at bytes 4+2i (msb) and 5+2i
  assign wbyte    = {idx_q, 1'b0} + `FPI_OB_WDAT;
  assign BUSY_OUT = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      state_q       <= ST_IDLE;
      prev_q        <= `FPI_CMD_NONE;
      code_q        <= `FPI_CMD_NONE;
      ack_q         <= `FPI_CMD_NONE;
      cerr_q        <= `FPI_ERR_NONE;
      win_q         <= `FPI_WIN_RST;
      cnt_q         <= 8'h00;
      start_q       <= 16'h0000;
      idx_q         <= 3'd0;
      prst_q        <= `FPI_PRST_RST;
      REG_WR_OUT    <= 1'b0;
      REG_WADDR_OUT <= 16'h0000;
      REG_WDATA_OUT <= 16'h0000;
      CMD_STB_OUT   <= 1'b0;
      CMD_CODE_OUT  <= 8'h00;
    end else if (CE_IN) begin
      // strobes last one cycle
      REG_WR_OUT  <= 1'b0;
      CMD_STB_OUT <= 1'b0;
      // outside event raises the program-reset bit
      if (PRG_RST_SET_IN) begin
        prst_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          // a command counts only when the byte changes
          if (cmd_byte != prev_q) begin
            prev_q  <= cmd_byte;
            code_q  <= cmd_byte;
            cnt_q   <= cnt_byte;
            start_q <= start_w;
            idx_q   <= 3'd0;
            case (cmd_byte)
              `FPI_CMD_NONE: begin
                // no action, answers untouched
                state_q <= ST_IDLE;
              end
              `FPI_CMD_WIN: begin
                // move the read window
                win_q  <= start_w;
                ack_q  <= cmd_byte;
                cerr_q <= `FPI_ERR_NONE;
              end
              `FPI_CMD_WRITE: begin
                // count must be one to six
                if (cnt_byte == 8'h00 || cnt_byte > `FPI_WR_REGS) begin
                  ack_q  <= `FPI_ACK_FAIL;
                  cerr_q <= `FPI_ERR_COUNT;
                end else begin
                  state_q <= ST_WR;
                end
              end
              `FPI_CMD_CLRPR: begin
                // clear, but a set in the same cycle wins
                prst_q <= PRG_RST_SET_IN;
                ack_q  <= cmd_byte;
                cerr_q <= `FPI_ERR_NONE;
              end
              default: begin
                // handed to the instrument's own command logic
                CMD_STB_OUT  <= 1'b1;
                CMD_CODE_OUT <= cmd_byte;
                state_q      <= ST_EXT;
              end
            endcase
          end
        end
        ST_WR: begin
          // present one sixteen-bit word
          REG_WR_OUT    <= 1'b1;
          REG_WADDR_OUT <= start_q + {13'h0000, idx_q};
          REG_WDATA_OUT <= {ob_flat[8*wbyte +: 8], ob_flat[8*(wbyte + 4'h1) +: 8]};
          state_q       <= ST_WCHK;
        end
        ST_WCHK: begin
          // the write is on the port now; judge it
          if (REG_WERR_IN != `FPI_ERR_NONE) begin
            ack_q   <= `FPI_ACK_FAIL;
            cerr_q  <= REG_WERR_IN;
            state_q <= ST_IDLE;
          end else if ({5'h00, idx_q} + 8'h01 == cnt_q) begin
            ack_q   <= code_q;
            cerr_q  <= `FPI_ERR_NONE;
            state_q <= ST_IDLE;
          end else begin
            idx_q   <= idx_q + 3'd1;
            state_q <= ST_WR;
          end
        end
        ST_EXT: begin
          // wait for the outside command logic
          if (CMD_DONE_IN) begin
            ack_q   <= (CMD_ERR_IN == `FPI_ERR_NONE) ? code_q : `FPI_ACK_FAIL;
            cerr_q  <= CMD_ERR_IN;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read window scan
  // ----------------------------------------------------------------
  assign ridx_nx = (scan_q == `FPI_RD_REGS - 1) ? 4'h0 : scan_q + 4'h1;

  // walks the twelve window registers without pause
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      scan_q        <= 4'h0;
      ridx_q        <= 4'hF;
      REG_RADDR_OUT <= 16'h0000;
    end else if (CE_IN) begin
      scan_q        <= ridx_nx;
      ridx_q        <= scan_q;
      REG_RADDR_OUT <= win_q + {12'h000, scan_q};
    end
  end

  // ----------------------------------------------------------------
  // input image, stage one: address and block configuration
  // ----------------------------------------------------------------
  assign nblk_eff = (NBLK_IN > `FPI_BLK_MAX) ? `FPI_BLK_MAX : NBLK_IN;
  assign blk_in   = IIMG_ADDR_IN[7:4] - `FPI_BLK_FIRST;
  assign blk_used = (IIMG_ADDR_IN >= `FPI_IB_BYTES) && (blk_in < nblk_eff);

  // latch address and pick the block's configuration
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      a_q          <= 8'h00;
      fmt_q        <= 1'b0;
      VAL_TYPE_OUT <= `FPI_TYPE_UNUSED;
      VAL_FB_OUT   <= 4'h0;
    end else if (CE_IN) begin
      a_q <= IIMG_ADDR_IN;
      if (blk_used) begin
        VAL_TYPE_OUT <= cfg_type[blk_in];
        VAL_FB_OUT   <= cfg_fb[blk_in];
        fmt_q        <= BLK_FMT_IN[blk_in];
      end else begin
        VAL_TYPE_OUT <= `FPI_TYPE_UNUSED;
        VAL_FB_OUT   <= 4'h0;
        fmt_q        <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // input image, stage two: byte selection
  // ----------------------------------------------------------------
  assign rsel      = a_q[4:1] - 4'h4;
  assign rword     = rd_flat[16*rsel +: 16];
  assign stat_word = {INST_STAT_IN[15:1], prst_q};

  fpi_blk_fmt u_fmt (
    .fmt_int_in (fmt_q),
    .off_in     (a_q[3:0]),
    .err_in     (VAL_ERR_IN),
    .stat_in    (VAL_STAT_IN),
    .a_in       (VAL_A_IN),
    .adec_in    (VAL_ADEC_IN),
    .b_in       (VAL_B_IN),
    .bdec_in    (VAL_BDEC_IN),
    .byte_out   (fmt_byte)
  );

  // registered image byte, two cycles after the address
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      IIMG_DATA_OUT <= 8'h00;
    end else if (CE_IN) begin
      if (a_q < `FPI_IB_BYTES) begin
        case (a_q[4:0])
          `FPI_IB_ERR_HI:  IIMG_DATA_OUT <= INST_ERR_IN[15:8];
          `FPI_IB_ERR_LO:  IIMG_DATA_OUT <= INST_ERR_IN[7:0];
          `FPI_IB_STAT_HI: IIMG_DATA_OUT <= stat_word[15:8];
          `FPI_IB_STAT_LO: IIMG_DATA_OUT <= stat_word[7:0];
          `FPI_IB_ACK:     IIMG_DATA_OUT <= ack_q;
          `FPI_IB_CERR:    IIMG_DATA_OUT <= cerr_q;
          `FPI_IB_WIN_HI:  IIMG_DATA_OUT <= win_q[15:8];
          `FPI_IB_WIN_LO:  IIMG_DATA_OUT <= win_q[7:0];
          default: begin
            // read words, msb at even byte
            IIMG_DATA_OUT <= a_q[0] ? rword[7:0] : rword[15:8];
          end
        endcase
      end else if (VAL_TYPE_OUT == `FPI_TYPE_UNUSED) begin
        // unused or beyond the active blocks
        IIMG_DATA_OUT <= 8'h00;
      end else begin
        IIMG_DATA_OUT <= fmt_byte;
      end
    end
  end

endmodule

// ===== fpi_process_image_asserts.sv
`timescale 1ns/1ps
// --------------------------------
// port checker for the image block
// --------------------------------
module fpi_process_image_asserts (
  input wire        CLK_SYS_IN,
  input wire        RST_N_IN,
  input wire        CE_IN,
  input wire        OIMG_WR_IN,
  input wire [3:0]  OIMG_ADDR_IN,
  input wire [7:0]  OIMG_DATA_IN,
  input wire [7:0]  IIMG_ADDR_IN,
  input wire [7:0]  IIMG_DATA_OUT,
  input wire [15:0] INST_ERR_IN,
  input wire        REG_WR_OUT,
  input wire [15:0] REG_WADDR_OUT,
  input wire [15:0] REG_WDATA_OUT,
  input wire        CMD_STB_OUT,
  input wire [7:0]  CMD_CODE_OUT,
  input wire        CMD_DONE_IN,
  input wire        BUSY_OUT
);
  reg  [7:0]  sh_q [0:15];  // copy of master block
  reg  [2:0]  up_q;         // edges since reset
  reg         pend_q;       // other command open
  wire [15:0] idx = REG_WADDR_OUT - {sh_q[2], sh_q[3]};
  wire [3:0]  bi  = {idx[2:0], 1'b0} + 4'h4;
  wire        ok  = (up_q > 3'h3);
  // copy writes, age after reset, open command
  always @(posedge CLK_SYS_IN) begin
    if (CE_IN && OIMG_WR_IN)
      sh_q[OIMG_ADDR_IN] <= OIMG_DATA_IN;
    if (!RST_N_IN) begin
      up_q   <= 3'h0;
      pend_q <= 1'b0;
    end else begin
      up_q   <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      pend_q <= CMD_STB_OUT | (pend_q & ~CMD_DONE_IN);
    end
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_wr_pulse; REG_WR_OUT |=> !REG_WR_OUT; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_wr_busy; REG_WR_OUT |-> BUSY_OUT; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write while idle");
  property p_stb_pulse;
    CMD_STB_OUT |=> !CMD_STB_OUT ##1 (!CMD_STB_OUT || CMD_CODE_OUT != $past(CMD_CODE_OUT, 2));
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("command ran twice");
  property p_stb_code; CMD_STB_OUT |-> !(CMD_CODE_OUT inside {8'h00, [8'hFA:8'hFC]}); endproperty
  a_stb_code: assert property (p_stb_code) else $error("own code sent out");
  property p_wr_step;
    REG_WR_OUT ##2 REG_WR_OUT |-> REG_WADDR_OUT == $past(REG_WADDR_OUT, 2) + 16'h0001;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write address step");
  property p_wr_data;
    REG_WR_OUT |-> idx < 16'h0006 && REG_WDATA_OUT == {sh_q[bi], sh_q[bi + 4'h1]};
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write word wrong");
  property p_err_byte;
    ok && $past(IIMG_ADDR_IN, 2) == 8'h00 && $stable(INST_ERR_IN)
      && $past(INST_ERR_IN, 2) == INST_ERR_IN |-> IIMG_DATA_OUT == INST_ERR_IN[15:8];
  endproperty
  a_err_byte: assert property (p_err_byte) else $error("error byte wrong");
  property p_tail_zero; ok && $past(IIMG_ADDR_IN, 2) > 8'hDF |-> IIMG_DATA_OUT == 8'h00; endproperty
  a_tail_zero: assert property (p_tail_zero) else $error("byte past 223 set");
  property p_done_idle; pend_q && CMD_DONE_IN |=> !BUSY_OUT; endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  c_burst: cover property (REG_WR_OUT ##2 REG_WR_OUT);
  c_other: cover property (CMD_STB_OUT);
  c_done: cover property (BUSY_OUT ##1 !BUSY_OUT);
endmodule

// ===== fpi_master_model.sv
`timescale 1ns/1ps
// --------------------------------
// fieldbus master side of the image
// --------------------------------
module fpi_master_model (
  input  wire       clk_in,
  output reg        wr_out,
  output reg  [3:0] addr_out,
  output reg  [7:0] data_out,
  output reg  [7:0] iaddr_out,
  input  wire [7:0] idata_in
);
  reg [7:0] last_q = 8'h00;  // last command code sent
  initial begin
    wr_out = 1'b0;
    addr_out = 4'h0;
    data_out = 8'h00;
    iaddr_out = 8'h00;
  end
  // one byte into the block, data scrambled once released
  task put_byte(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      #1 wr_out = 1'b1;
      addr_out = a;
      data_out = d;
      @(posedge clk_in);
      #1 wr_out = 1'b0;
      data_out = ~d;
    end
  endtask
  // word as two bytes, high byte first
  task put_word(input [3:0] a, input [15:0] w);
    begin
      put_byte(a, w[15:8]);
      put_byte(a + 4'h1, w[7:0]);
    end
  endtask
  // a repeated code gets a zero in between
  task put_cmd(input [7:0] c);
    begin
      if (c == last_q)
        put_byte(4'h0, 8'h00);
      put_byte(4'h0, c);
      last_q = c;
    end
  endtask
  // image byte, read three edges after the address
  task get_byte(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_in);
      #1 iaddr_out = a;
      repeat (3) @(posedge clk_in);
      #1 d = idata_in;
    end
  endtask
endmodule

// ===== fpi_process_image_tb_top.sv
`timescale 1ns/1ps
module fpi_process_image_tb_top;
  reg         CLK_SYS_IN = 1'b0;
  reg         RST_N_IN = 1'b0;
  reg         PRG_RST_SET_IN = 1'b0;
  reg         CMD_DONE_IN = 1'b0;
  reg  [15:0] INST_ERR_IN = 16'h0000;
  reg  [15:0] INST_STAT_IN = 16'h8421;
  reg  [3:0]  NBLK_IN = 4'h2;
  reg  [59:0] BLK_TYPE_IN = 60'h21;  // blocks one and two in use
  reg  [11:0] BLK_FMT_IN = 12'h002;  // block two integer
  reg  [47:0] BLK_FB_IN = 48'h53;
  reg  [7:0]  REG_WERR_IN = 8'h00;
  reg  [7:0]  CMD_ERR_IN = 8'h00;
  wire        CE_IN = 1'b1;
  wire        OIMG_WR_IN, REG_WR_OUT, CMD_STB_OUT, BUSY_OUT;
  wire [3:0]  OIMG_ADDR_IN, VAL_FB_OUT;
  wire [4:0]  VAL_TYPE_OUT;
  wire [7:0]  OIMG_DATA_IN, IIMG_ADDR_IN, IIMG_DATA_OUT, CMD_CODE_OUT;
  wire [15:0] REG_RADDR_OUT, REG_WADDR_OUT, REG_WDATA_OUT;
  // instrument side: registers and block values
  wire [15:0] REG_RDATA_IN = REG_RADDR_OUT ^ 16'h5A00;
  wire [31:0] VAL_ERR_IN = {8'hE0, 20'h00000, VAL_FB_OUT};
  wire [31:0] VAL_STAT_IN = {8'h5A, 20'h00000, VAL_FB_OUT};
  wire [31:0] VAL_A_IN = {24'hA12233, 4'h0, VAL_FB_OUT};
  wire [15:0] VAL_ADEC_IN = {12'hAD0, VAL_FB_OUT};
  wire [31:0] VAL_B_IN = {8'hB1, 20'h00000, VAL_FB_OUT};
  wire [15:0] VAL_BDEC_IN = {12'hBDE, VAL_FB_OUT};
  integer     err_total = 0;
  integer     n_tests = 0;
  reg  [7:0]  wr_cnt = 8'h00;  // write strobes seen
  reg  [7:0]  w0, b;
  reg  [2:0]  dly = 3'h0;      // other-command delay
  reg  [15:0] wa_last = 16'h0000;  // address of last write strobe
  reg  [15:0] wd_last = 16'h0000;  // data of last write strobe
  reg  [7:0]  code_seen = 8'h00;   // code of last outside command
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  fpi_process_image fpi_process_image_i (
    .CLK_SYS_IN, .RST_N_IN, .CE_IN, .OIMG_WR_IN, .OIMG_ADDR_IN, .OIMG_DATA_IN,
    .IIMG_ADDR_IN, .IIMG_DATA_OUT, .INST_ERR_IN, .INST_STAT_IN, .PRG_RST_SET_IN,
    .NBLK_IN, .BLK_TYPE_IN, .BLK_FMT_IN, .BLK_FB_IN, .VAL_TYPE_OUT, .VAL_FB_OUT,
    .VAL_ERR_IN, .VAL_STAT_IN, .VAL_A_IN, .VAL_ADEC_IN, .VAL_B_IN, .VAL_BDEC_IN,
    .REG_RADDR_OUT, .REG_RDATA_IN, .REG_WR_OUT, .REG_WADDR_OUT, .REG_WDATA_OUT,
    .REG_WERR_IN, .CMD_STB_OUT, .CMD_CODE_OUT, .CMD_DONE_IN, .CMD_ERR_IN, .BUSY_OUT);
  fpi_master_model fpi_master_model_i (.clk_in(CLK_SYS_IN), .wr_out(OIMG_WR_IN),
    .addr_out(OIMG_ADDR_IN), .data_out(OIMG_DATA_IN), .iaddr_out(IIMG_ADDR_IN),
    .idata_in(IIMG_DATA_OUT));
  // count strobes, finish other commands three cycles on
  always @(posedge CLK_SYS_IN) begin
    if (REG_WR_OUT === 1'b1) begin
      wr_cnt  <= wr_cnt + 8'h01;
      wa_last <= REG_WADDR_OUT;
      wd_last <= REG_WDATA_OUT;
    end
    if (CMD_STB_OUT === 1'b1)
      code_seen <= CMD_CODE_OUT;
    CMD_DONE_IN <= (dly == 3'h1);
    dly <= (CMD_STB_OUT === 1'b1) ? 3'h3 : (dly == 3'h0) ? dly : dly - 3'h1;
  end
  task results;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk8(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    begin
      fpi_master_model_i.get_byte(a, b);
      chk8($sformatf("image byte %0d", a), e, b);
    end
  endtask
  // send a command, wait for idle under a bound
  task cmd(input [7:0] c);
    integer n;
    begin
      fpi_master_model_i.put_cmd(c);
      n = 0;
      repeat (3) @(posedge CLK_SYS_IN);
      while (BUSY_OUT !== 1'b0 && n < 300) begin
        @(posedge CLK_SYS_IN);
        #2 n = n + 1;
      end
      if (n == 300) begin
        chk8("busy", 8'h00, 8'h01);
        results;
      end
    end
  endtask
  task t_reset;
    begin
      rchk(8'h03, 8'h21);
      rchk(8'h04, 8'h00);
      rchk(8'h01, 8'h00);
      INST_ERR_IN = 16'hBEEF;
      rchk(8'h00, 8'hBE);
      rchk(8'h02, 8'h84);
    end
  endtask
  task t_window;
    begin
      fpi_master_model_i.put_word(4'h2, 16'h0120);
      cmd(8'hFA);
      repeat (20) @(posedge CLK_SYS_IN);
      rchk(8'h04, 8'hFA);
      rchk(8'h07, 8'h20);
      rchk(8'h08, 8'h5B);
      rchk(8'h1F, 8'h2B);
    end
  endtask
  task t_write;
    integer i;
    begin
      fpi_master_model_i.put_byte(4'h1, 8'h06);
      for (i = 0; i < 6; i = i + 1)
        fpi_master_model_i.put_word(4'h4 + 2 * i, {8'hC0, i[7:0]});
      w0 = wr_cnt;
      cmd(8'hFB);
      chk8("write strobes", 8'h06, wr_cnt - w0);
      chk8("last write address", 8'h25, wa_last[7:0]);
      chk8("last write data msb", 8'hC0, wd_last[15:8]);
      chk8("last write data lsb", 8'h05, wd_last[7:0]);
      rchk(8'h05, 8'h00);
    end
  endtask
  task t_bad;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        fpi_master_model_i.put_byte(4'h1, (k == 0) ? 8'h00 : 8'h07);
        w0 = wr_cnt;
        cmd(8'hFB);
        chk8("write strobes", 8'h00, wr_cnt - w0);
        rchk(8'h04, 8'hF0);
        rchk(8'h05, 8'h01);
      end
      fpi_master_model_i.put_byte(4'h1, 8'h01);
      fpi_master_model_i.put_byte(4'h0, 8'hFB);
      repeat (10) @(posedge CLK_SYS_IN);
      chk8("write strobes", 8'h00, wr_cnt - w0);
    end
  endtask
  task t_fail;
    begin
      fpi_master_model_i.put_byte(4'h1, 8'h03);
      REG_WERR_IN = 8'h33;
      w0 = wr_cnt;
      cmd(8'hFB);
      REG_WERR_IN = 8'h00;
      chk8("write strobes", 8'h01, wr_cnt - w0);
      rchk(8'h04, 8'hF0);
      rchk(8'h05, 8'h33);
      cmd(8'hFC);
      rchk(8'h03, 8'h20);
      PRG_RST_SET_IN = 1'b1;
      @(posedge CLK_SYS_IN);
      #1 PRG_RST_SET_IN = 1'b0;
      rchk(8'h03, 8'h21);
    end
  endtask
  task t_other;
    begin
      cmd(8'h10);
      chk8("command code", 8'h10, code_seen);
      rchk(8'h04, 8'h10);
      CMD_ERR_IN = 8'h05;
      cmd(8'h11);
      chk8("command code", 8'h11, code_seen);
      CMD_ERR_IN = 8'h00;
      rchk(8'h04, 8'hF0);
      rchk(8'h05, 8'h05);
    end
  endtask
  task t_blocks;
    begin
      rchk(8'h20, 8'hE0);
      rchk(8'h24, 8'h5A);
      rchk(8'h2B, 8'h03);
      rchk(8'h2C, 8'hB1);
      rchk(8'h37, 8'h05);
      rchk(8'h38, 8'hAD);
      rchk(8'h3A, 8'hB1);
      rchk(8'h3E, 8'hBD);
      chk8("block type and fb", 8'h15, {VAL_TYPE_OUT[3:0], VAL_FB_OUT});
      rchk(8'hE0, 8'h00);
      NBLK_IN = 4'h1;
      rchk(8'h34, 8'h00);
    end
  endtask
  initial begin
    repeat (10) @(posedge CLK_SYS_IN);
    #1 RST_N_IN = 1'b1;
    t_reset;
    t_window;
    t_write;
    t_bad;
    t_fail;
    t_other;
    t_blocks;
    results;
  end
endmodule
bind fpi_process_image fpi_process_image_asserts fpi_process_image_asserts_i (
  .CLK_SYS_IN, .RST_N_IN, .CE_IN, .OIMG_WR_IN, .OIMG_ADDR_IN, .OIMG_DATA_IN,
  .IIMG_ADDR_IN, .IIMG_DATA_OUT, .INST_ERR_IN, .REG_WR_OUT, .REG_WADDR_OUT,
  .REG_WDATA_OUT, .CMD_STB_OUT, .CMD_CODE_OUT, .CMD_DONE_IN, .BUSY_OUT);
